// *** rtl/sxs_pkg.sv ***
package sxs_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register byte addresses (one 32-bit word each)
	localparam logic [7:0] ADR_CMD = 8'h00;
	localparam logic [7:0] ADR_ACC = 8'h04;
	localparam logic [7:0] ADR_STAT = 8'h08;
	localparam logic [7:0] ADR_DIRA = 8'h0c;
	localparam logic [7:0] ADR_DIRB = 8'h10;
	localparam logic [7:0] ADR_DIRC = 8'h14;
	localparam logic [7:0] ADR_WDT = 8'h18;
	localparam logic [7:0] ADR_PWR = 8'h1c;
	localparam logic [7:0] ADR_FADR = 8'h20;
	localparam logic [7:0] ADR_FDAT = 8'h24;

	////////////////////////////////////////////////////////////////////////
	// Operand codes of the direction load
	localparam logic [7:0] DIR_SEL_A = 8'h05;
	localparam logic [7:0] DIR_SEL_B = 8'h06;
	localparam logic [7:0] DIR_SEL_C = 8'h07;

	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [7:0] WDT_CLEAR = 8'h00;
	localparam logic [7:0] ACC_RST = 8'h00;
	localparam int FILE_DEPTH = 128;
	localparam int FILE_AW = 7;
	localparam int PWR_WAKE_BIT = 0;

	////////////////////////////////////////////////////////////////////////
	// Types
	typedef enum logic [3:0] {
		nop_op = 4'h0,
		literal_minus_acc_op = 4'h1,
		file_minus_acc_op = 4'h2,
		file_minus_acc_borrow_op = 4'h3,
		nibble_exchange_op = 4'h4,
		literal_xor_op = 4'h5,
		file_xor_op = 4'h6,
		direction_load_op = 4'h7,
		low_power_op = 4'h8
	} sxs_op_e;

	typedef struct packed {
		logic [3:0] op;
		logic [2:0] rsv;
		logic dest;
		logic [7:0] operand;
	} sxs_cmd_s;

	typedef struct packed {
		logic timeout_status_n;
		logic powerdown_status_n;
		logic zero;
		logic digit_carry;
		logic carry;
	} sxs_stat_s;

	localparam sxs_stat_s STAT_RST = 5'b11000;

	typedef struct packed {
		logic [7:0] res;
		logic c;
		logic dc;
	} sxs_sub_s;

	typedef enum logic [1:0] {
		PWR_RUN = 2'b01,
		PWR_SLEEP = 2'b10
	} sxs_pwr_e;

endpackage

// *** rtl/sxs_exec.sv ***
// Implementation choices: the Wishbone register port and the placing of the registers.
`timescale 1ns/100ps

// Behaviour
// - The literal subtract puts the literal minus the accumulator into the accumulator.
// - Subtracts set carry unless the subtrahend plus any borrow is larger, digit carry likewise on low nibbles, and update zero.
// - The file subtract computes the addressed file register minus the accumulator.
// - The borrow subtract also takes away the inverted carry and updates carry, digit carry and zero.
// - For the file operations, a destination bit of 0 writes the result to the accumulator and 1 writes it to the file register.
// - The nibble exchange swaps the two halves of the file register and leaves status alone.
// - The literal XOR stores accumulator XOR literal in the accumulator and touches only zero.
// - The file XOR routes accumulator XOR file register by the destination bit and touches only zero.
// - The direction load copies the accumulator into port A, B or C direction for operand 5, 6 or 7.
// - Low-power entry clears the watchdog counter and its prescaler.
// - Low-power entry clears the power-down flag, sets the time-out flag and halts the core.
module sxs_exec
	import sxs_pkg::*;
#(
	parameter logic [7:0] DIR_RST = 8'hff,
	parameter int PRE_W = 8
) (
	// System
	input wire logic clk_sys,
	input wire logic resetn,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Core state
	output logic [7:0] port_a_direction,
	output logic [7:0] port_b_direction,
	output logic [7:0] port_c_direction,
	output logic core_halted
);

	////////////////////////////////////////////////////////////////////////
	// Functions
	function automatic sxs_sub_s sxs_sub(input logic [7:0] a,
		input logic [7:0] b, input logic bin);
		logic [8:0] full;
		logic [4:0] low;
		sxs_sub_s r;
		full = {1'b0, a} - {1'b0, b} - {8'h00, bin};
		low = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, bin};
		r.res = full[7:0];
		r.c = ~full[8];
		r.dc = ~low[4];
		return r;
	endfunction

	function automatic logic sxs_zero(input logic [7:0] v);
		return v == BYTE_ZERO;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// State
	logic ack_ff, nxt_ack;
	logic [31:0] rdat_ff, nxt_rdat;
	logic [15:0] cmd_ff, nxt_cmd;
	logic [7:0] acc_ff, nxt_acc;
	sxs_stat_s stat_ff, nxt_stat;
	logic [7:0] dira_ff, nxt_dira;
	logic [7:0] dirb_ff, nxt_dirb;
	logic [7:0] dirc_ff, nxt_dirc;
	logic [7:0] wdt_ff, nxt_wdt;
	logic [PRE_W-1:0] pre_ff, nxt_pre;
	sxs_pwr_e pwr_ff, nxt_pwr;
	logic [FILE_AW-1:0] fadr_ff, nxt_fadr;
	logic [7:0] file_mem [FILE_DEPTH];

	logic req, wr;
	logic exec;
	sxs_cmd_s cmd;
	logic [7:0] fsrc;
	logic [7:0] res;
	sxs_sub_s sub;
	logic file_we;
	logic [FILE_AW-1:0] file_wadr;
	logic [7:0] file_wdat;
	logic wdt_ovf;

	// A held strobe is taken again only after ack has dropped
	assign req = wb_cyc_i & wb_stb_i & ~ack_ff;
	assign wr = req & wb_we_i;
	assign cmd = sxs_cmd_s'(wb_dat_i[15:0]);
	assign fsrc = file_mem[cmd.operand[FILE_AW-1:0]];
	// Commands are dropped while halted: the core clock is stopped
	assign exec = wr & (wb_adr_i == ADR_CMD) & (&wb_sel_i[1:0])
		& (pwr_ff == PWR_RUN);
	assign wdt_ovf = (&pre_ff) & (&wdt_ff);

	////////////////////////////////////////////////////////////////////////
	// Execution, status and watchdog
	always_comb begin
		nxt_acc = acc_ff;
		nxt_stat = stat_ff;
		nxt_dira = dira_ff;
		nxt_dirb = dirb_ff;
		nxt_dirc = dirc_ff;
		nxt_pwr = pwr_ff;
		nxt_cmd = cmd_ff;
		nxt_fadr = fadr_ff;
		nxt_pre = pre_ff + PRE_W'(1);
		nxt_wdt = (&pre_ff) ? wdt_ff + 8'h01 : wdt_ff;
		file_we = 1'b0;
		file_wadr = cmd.operand[FILE_AW-1:0];
		file_wdat = BYTE_ZERO;
		res = BYTE_ZERO;
		sub = '0;

		if (wr & wb_sel_i[0]) begin
			unique case (wb_adr_i)
				ADR_ACC: begin
					nxt_acc = wb_dat_i[7:0];
				end
				ADR_STAT: begin
					nxt_stat.carry = wb_dat_i[0];
					nxt_stat.digit_carry = wb_dat_i[1];
					nxt_stat.zero = wb_dat_i[2];
				end
				ADR_PWR: begin
					if (wb_dat_i[PWR_WAKE_BIT]) begin
						nxt_pwr = PWR_RUN;
					end
				end
				ADR_FADR: begin
					nxt_fadr = wb_dat_i[FILE_AW-1:0];
				end
				ADR_FDAT: begin
					file_we = 1'b1;
					file_wadr = fadr_ff;
					file_wdat = wb_dat_i[7:0];
				end
				default: begin
				end
			endcase
		end

		if (exec) begin
			nxt_cmd = wb_dat_i[15:0];
			unique case (cmd.op)
				literal_minus_acc_op: begin
					sub = sxs_sub(cmd.operand, acc_ff, 1'b0);
					nxt_acc = sub.res;
				end
				file_minus_acc_op: begin
					sub = sxs_sub(fsrc, acc_ff, 1'b0);
				end
				file_minus_acc_borrow_op: begin
					// Carry set means no borrow pending
					sub = sxs_sub(fsrc, acc_ff, ~stat_ff.carry);
				end
				nibble_exchange_op: begin
					res = {fsrc[3:0], fsrc[7:4]};
				end
				literal_xor_op: begin
					nxt_acc = acc_ff ^ cmd.operand;
					nxt_stat.zero = sxs_zero(acc_ff ^ cmd.operand);
				end
				file_xor_op: begin
					res = acc_ff ^ fsrc;
					nxt_stat.zero = sxs_zero(res);
				end
				direction_load_op: begin
					unique case (cmd.operand)
						DIR_SEL_A: nxt_dira = acc_ff;
						DIR_SEL_B: nxt_dirb = acc_ff;
						DIR_SEL_C: nxt_dirc = acc_ff;
						default: begin
						end
					endcase
				end
				low_power_op: begin
					nxt_wdt = WDT_CLEAR;
					nxt_pre = '0;
					nxt_stat.timeout_status_n = 1'b1;
					nxt_stat.powerdown_status_n = 1'b0;
					nxt_pwr = PWR_SLEEP;
				end
				default: begin
				end
			endcase

			if (cmd.op == literal_minus_acc_op
				|| cmd.op == file_minus_acc_op
				|| cmd.op == file_minus_acc_borrow_op) begin
				res = sub.res;
				nxt_stat.carry = sub.c;
				nxt_stat.digit_carry = sub.dc;
				nxt_stat.zero = sxs_zero(sub.res);
			end

			if (cmd.op == file_minus_acc_op
				|| cmd.op == file_minus_acc_borrow_op
				|| cmd.op == nibble_exchange_op
				|| cmd.op == file_xor_op) begin
				if (cmd.dest) begin
					file_we = 1'b1;
					file_wadr = cmd.operand[FILE_AW-1:0];
					file_wdat = res;
				end else begin
					nxt_acc = res;
				end
			end
		end

		// Overflow is an event and wins over a same-cycle clear
		if (wdt_ovf) begin
			nxt_stat.timeout_status_n = 1'b0;
			nxt_pwr = PWR_RUN;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bus answer
	always_comb begin
		nxt_ack = req;
		nxt_rdat = '0;
		if (req & ~wb_we_i) begin
			unique case (wb_adr_i)
				ADR_CMD: nxt_rdat = 32'(cmd_ff);
				ADR_ACC: nxt_rdat = 32'(acc_ff);
				ADR_STAT: nxt_rdat = 32'(stat_ff);
				ADR_DIRA: nxt_rdat = 32'(dira_ff);
				ADR_DIRB: nxt_rdat = 32'(dirb_ff);
				ADR_DIRC: nxt_rdat = 32'(dirc_ff);
				// Prescaler above the counter: one read shows both
				ADR_WDT: nxt_rdat = 32'({pre_ff, wdt_ff});
				ADR_PWR: nxt_rdat = 32'(pwr_ff == PWR_SLEEP);
				ADR_FADR: nxt_rdat = 32'(fadr_ff);
				ADR_FDAT: nxt_rdat = 32'(file_mem[fadr_ff]);
				default: nxt_rdat = '0;
			endcase
		end
	end

	// Registered answer costs a wait state but keeps bus paths short
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ack_ff <= 1'b0;
			rdat_ff <= '0;
		end else begin
			ack_ff <= nxt_ack;
			rdat_ff <= nxt_rdat;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registers
	// Watchdog keeps counting while halted, so it can wake the core
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			wdt_ff <= WDT_CLEAR;
			pre_ff <= '0;
		end else begin
			wdt_ff <= nxt_wdt;
			pre_ff <= nxt_pre;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			cmd_ff <= '0;
			acc_ff <= ACC_RST;
			stat_ff <= STAT_RST;
			dira_ff <= DIR_RST;
			dirb_ff <= DIR_RST;
			dirc_ff <= DIR_RST;
			pwr_ff <= PWR_RUN;
			fadr_ff <= '0;
		end else begin
			cmd_ff <= nxt_cmd;
			acc_ff <= nxt_acc;
			stat_ff <= nxt_stat;
			dira_ff <= nxt_dira;
			dirb_ff <= nxt_dirb;
			dirc_ff <= nxt_dirc;
			pwr_ff <= nxt_pwr;
			fadr_ff <= nxt_fadr;
		end
	end

	// Data file has no reset, as in a real register file
	always_ff @(posedge clk_sys) begin
		if (file_we) begin
			file_mem[file_wadr] <= file_wdat;
		end
	end

	assign wb_ack_o = ack_ff;
	assign wb_dat_o = rdat_ff;
	assign port_a_direction = dira_ff;
	assign port_b_direction = dirb_ff;
	assign port_c_direction = dirc_ff;
	assign core_halted = (pwr_ff == PWR_SLEEP);

endmodule

// *** testbench/sxs_exec_asserts.sv ***
`timescale 1ns/100ps
module sxs_exec_asserts
	import sxs_pkg::*;
(
	// System
	input wire logic clk_sys,
	input wire logic resetn,
	// Bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// Core
	input wire logic [7:0] port_a_direction,
	input wire logic [7:0] port_b_direction,
	input wire logic [7:0] port_c_direction,
	input wire logic core_halted
);
	logic take;
	logic cmd_wr;
	logic dir_ld;
	assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign cmd_wr = take && wb_we_i && wb_adr_i == ADR_CMD && &wb_sel_i[1:0];
	assign dir_ld = cmd_wr && wb_dat_i[15:12] == 4'h7 && !core_halted;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	sequence sleep_req;
		cmd_wr && wb_dat_i[15:12] == 4'h8 && !core_halted;
	endsequence
	sequence wake_req;
		take && wb_we_i && wb_adr_i == ADR_PWR && wb_sel_i[0] && wb_dat_i[0];
	endsequence
	ack_one_cycle_a: assert property (take |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not a single cycle after request");
	idle_data_zero_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data not zero outside ack");
	acc_upper_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == ADR_ACC
		|-> wb_dat_o[31:8] == 24'h0) else $error("acc upper bits set");
	sleep_enter_a: assert property (sleep_req |=> core_halted)
		else $error("low-power entry did not halt");
	sleep_hold_a: assert property (core_halted && !wake_req
		|=> core_halted) else $error("left halt without wake");
	wake_exit_a: assert property (core_halted ##0 wake_req |=> !core_halted)
		else $error("wake write ignored");
	dir_a_cause_a: assert property (!$stable(port_a_direction) |->
		$past(dir_ld) && $past(wb_dat_i[7:0]) == DIR_SEL_A)
		else $error("port a direction changed without load");
	dir_b_cause_a: assert property (!$stable(port_b_direction) |->
		$past(dir_ld) && $past(wb_dat_i[7:0]) == DIR_SEL_B)
		else $error("port b direction changed without load");
	halt_dir_hold_a: assert property (core_halted
		|=> $stable(port_c_direction))
		else $error("direction changed while halted");
endmodule
bind sxs_exec sxs_exec_asserts u_chk (.clk_sys(clk_sys), .resetn(resetn),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.port_a_direction(port_a_direction), .port_b_direction(port_b_direction),
	.port_c_direction(port_c_direction), .core_halted(core_halted));

// *** testbench/testbench.sv ***
`timescale 1ns/100ps
module testbench
	import sxs_pkg::*;
;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] dat = 32'h0;
	logic [31:0] dat_o;
	logic [31:0] q;
	logic [31:0] rnd = 32'h0000000e;
	logic ack;
	logic halted;
	logic [7:0] dir_a;
	logic [7:0] dir_b;
	logic [7:0] dir_c;
	logic [23:0] dirs;
	logic [7:0] acc;
	logic [7:0] f;
	logic [7:0] k;
	logic [7:0] m;
	logic [7:0] res;
	logic [2:0] st;
	logic [3:0] op;
	logic [8:0] t9;
	logic [4:0] t5;
	logic lit;
	int errors = 0;
	int num_checks = 0;
	int cycles = 0;
	int i;
	always #4 clk_sys = ~clk_sys;
	sxs_exec DUT (.clk_sys(clk_sys), .resetn(resetn), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
		.wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.port_a_direction(dir_a), .port_b_direction(dir_b),
		.port_c_direction(dir_c), .core_halted(halted));
	////////////////////////////////////////
	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task automatic end_sim();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// Waits for ack with no fixed count; the cycle ceiling ends a hang
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_sys);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= v;
		do @(posedge clk_sys); while (ack !== 1'b1);
		q = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic rst_chk();
		resetn <= 1'b0;
		repeat (2) @(posedge clk_sys);
		resetn <= 1'b1;
		dirs = 24'hffffff;
		bus(1'b0, ADR_STAT, 32'h0);
		chk(q, 32'h18);
		chk({8'h0, dir_a, dir_b, dir_c}, {8'h0, dirs});
	endtask
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			end_sim();
		end
	end
	////////////////////////////////////////
	initial begin
		rst_chk();
		for (i = 0; i < 180; i++) begin
			rnd = xs(rnd);
			op = 4'(i % 6 + 1);
			lit = op == 4'h1 || op == 4'h5;
			acc = rnd[7:0];
			// Equal operands give the zero and no-borrow corner
			k = (i % 4 == 0) ? acc : rnd[15:8];
			f = (i % 4 == 1) ? acc : rnd[23:16];
			st = rnd[26:24];
			bus(1'b1, ADR_ACC, {24'h0, acc});
			bus(1'b1, ADR_STAT, {29'h0, st});
			bus(1'b1, ADR_FADR, {25'h0, rnd[31:25]});
			bus(1'b1, ADR_FDAT, {24'h0, f});
			bus(1'b1, ADR_CMD, {16'h0, op, 3'b000, rnd[27],
				lit ? k : {1'b0, rnd[31:25]}});
			m = lit ? k : f;
			t9 = {1'b0, m} - {1'b0, acc} - {8'h0, op == 4'h3 && !st[0]};
			t5 = {1'b0, m[3:0]} - {1'b0, acc[3:0]} - {4'h0, op == 4'h3 && !st[0]};
			res = (op == 4'h4) ? {f[3:0], f[7:4]} : (op > 4'h4) ? acc ^ m : t9[7:0];
			if (op < 4'h4)
				st = {res == 8'h00, !t5[4], !t9[8]};
			else if (op > 4'h4)
				st[2] = res == 8'h00;
			if (lit || !rnd[27])
				acc = res;
			else
				f = res;
			bus(1'b0, ADR_ACC, 32'h0);
			chk(q, {24'h0, acc});
			bus(1'b0, ADR_STAT, 32'h0);
			chk(q & 32'h7, {29'h0, st});
			bus(1'b0, ADR_FDAT, 32'h0);
			chk(q, {24'h0, f});
		end
		for (i = 4; i < 8; i++) begin
			rnd = xs(rnd);
			bus(1'b1, ADR_ACC, {24'h0, rnd[7:0]});
			bus(1'b1, ADR_CMD, {16'h0, 8'h70, 8'(i)});
			if (i > 4)
				dirs[8 * (7 - i) +: 8] = rnd[7:0];
			chk({8'h0, dir_a, dir_b, dir_c}, {8'h0, dirs});
		end
		// Undefined op code leaves the accumulator alone but is recorded
		bus(1'b1, ADR_CMD, 32'h9000);
		bus(1'b0, ADR_ACC, 32'h0);
		chk(q, {24'h0, rnd[7:0]});
		bus(1'b0, ADR_CMD, 32'h0);
		chk(q, 32'h9000);
		bus(1'b1, ADR_CMD, 32'h8000);
		chk({31'h0, halted}, 32'h1);
		bus(1'b0, ADR_WDT, 32'h0);
		chk({q[7:0], 7'h0, q[15:8] < 8'h08}, 16'h1);
		bus(1'b0, ADR_STAT, 32'h0);
		chk(q & 32'h18, 32'h10);
		bus(1'b1, ADR_CMD, {16'h0, 8'h70, DIR_SEL_A});
		chk({8'h0, dir_a, dir_b, dir_c}, {8'h0, dirs});
		bus(1'b1, ADR_PWR, 32'h1);
		chk({31'h0, halted}, 32'h0);
		bus(1'b0, 8'h40, 32'h0);
		chk(q, 32'h0);
		rst_chk();
		end_sim();
	end
endmodule
